// [hdl/rtcal_pkg.sv]
// register map, reset values and carriers of the rtc calendar core
`default_nettype none
package rtcal_pkg;
    localparam logic [7:0] RTCAL_OFS_CFG1  = 8'h00;
    localparam logic [7:0] RTCAL_OFS_CFG2  = 8'h01;
    localparam logic [7:0] RTCAL_OFS_INTEN = 8'h04;
    localparam logic [7:0] RTCAL_OFS_FLAGS = 8'h05;
    localparam logic [7:0] RTCAL_OFS_SEC   = 8'h06;
    localparam logic [7:0] RTCAL_OFS_MIN   = 8'h07;
    localparam logic [7:0] RTCAL_OFS_HRS   = 8'h08;
    localparam logic [7:0] RTCAL_OFS_WDAY  = 8'h09;
    localparam logic [7:0] RTCAL_OFS_MDAY  = 8'h0a;
    localparam logic [7:0] RTCAL_OFS_MON   = 8'h0b;
    localparam logic [7:0] RTCAL_OFS_YEAR  = 8'h0c;
    localparam logic [7:0] RTCAL_OFS_ALM   = 8'h0d;
    localparam logic [7:0] RTCAL_OFS_ALM_L = 8'h12;
    localparam int RTCAL_B_LOS   = 7;
    localparam int RTCAL_B_OSF   = 6;
    localparam int RTCAL_B_TIF   = 2;
    localparam int RTCAL_B_A2F   = 1;
    localparam int RTCAL_B_A1F   = 0;
    localparam int RTCAL_B_EXT_REFERENCE_ENABLE  = 7;
    localparam int RTCAL_B_PIN_FUNCTION_SELECT = 6;
    localparam int RTCAL_B_OSC_FLAG_DISABLE  = 6;
    localparam int RTCAL_B_TIE   = 2;
    localparam int RTCAL_B_A2IE  = 1;
    localparam int RTCAL_B_ALARM_ONE_IRQ_ENABLE  = 0;
    localparam int RTCAL_B_RDRUN = 2;
    localparam int RTCAL_B_SET   = 1;
    localparam int RTCAL_B_CENT  = 7;
    localparam int RTCAL_B_MMASK = 7;
    localparam int RTCAL_B_YMASK = 6;
    localparam int RTCAL_B_DYDT  = 6;
    localparam logic [7:0] RTCAL_RST_CFG1  = 8'h0e;
    localparam logic [7:0] RTCAL_RST_CFG2  = 8'h0c;
    localparam logic [7:0] RTCAL_RST_INTEN = 8'h00;
    localparam logic [7:0] RTCAL_RST_FLAGS = 8'h40;
    localparam logic [7:0] RTCAL_RST_ALMON = 8'hc0;
    localparam logic [7:0] RTCAL_MSK_SEC   = 8'h7f;
    localparam logic [7:0] RTCAL_MSK_HRS   = 8'h3f;
    localparam logic [7:0] RTCAL_MSK_WDAY  = 8'h07;
    localparam logic [7:0] RTCAL_MSK_MON   = 8'h9f;
    localparam logic [7:0] RTCAL_MSK_ALMON = 8'hdf;
    localparam logic [7:0] RTCAL_MSK_CFG2  = 8'h4e;
    localparam logic [7:0] RTCAL_MSK_INTEN = 8'h47;
    localparam logic [7:0] RTCAL_MSK_FLAGS = 8'hc7;
    localparam logic [7:0] RTCAL_MAX_SEC   = 8'h59;
    localparam logic [7:0] RTCAL_MAX_HRS   = 8'h23;
    localparam logic [7:0] RTCAL_MAX_WDAY  = 8'h07;
    localparam logic [7:0] RTCAL_MAX_MON   = 8'h12;
    localparam logic [7:0] RTCAL_MAX_YEAR  = 8'h99;
    localparam logic [7:0] RTCAL_ONE       = 8'h01;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } rtcal_req_t;
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hrs;
        logic [7:0] wday;
        logic [7:0] mday;
        logic [7:0] mon;
        logic [7:0] year;
    } rtcal_cal_t;
    localparam rtcal_cal_t RTCAL_RST_CAL = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
endpackage
`default_nettype wire

// [hdl/rtcal_core.sv]
// calendar, alarm one and interrupt flags of the rtc
// Summary of operation
// - interrupt enable bit 0 gates the first alarm's interrupt.
// - status flags at 7,6,2,1,0; oscillator-stop resets to 1; a read of the flag register clears all.
// - reference-lost flag sets on deviation, only while external reference is enabled.
// - oscillator-stop flag sets when oscillator stops; forced 0 while disable bit set.
// - countdown-zero flag sets when the countdown reaches zero.
// - second alarm flag sets when that alarm triggers.
// - first alarm flag sets when the first alarm triggers.
// - seconds are bcd, tens 6:4, units 3:0, reset zero.
// - minutes are bcd, tens 6:4, units 3:0, reset zero.
// - hours are bcd, tens 5:4; bit 6 reserved, host writes zero.
// - date is bcd, tens 5:4, units 3:0, resets to one.
// - month bcd, tens bit 4, resets to one; bit 7 is century.
// - year is two bcd digits, tens 7:4, reset zero.
// - alarm settings at 0Dh..12h; bit 7 and month bit 6 are masks.
// - with all masks clear every field must equal for a trigger.
// - masks give once per second, then sec, min, hour matches.
// - year mask adds month match; day select compares weekday instead.
// - day select 0 compares date of month, 1 compares weekday.
// - alarm match with enable set drives the interrupt pin while the external reference is off.
// - pin select 0 gives square wave, 1 gives interrupt.
// - rising set-time bit loads calendar registers into the running chain.
`default_nettype none
module rtcal_core
    import rtcal_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire rtcal_req_t reg_req,
    output logic [7:0]      reg_rdata,
    input  wire logic       sec_tick,
    input  wire logic       osc_stopped_pin,
    input  wire logic       ref_deviation_pin,
    input  wire logic       countdown_zero,
    input  wire logic       alarm_two_match,
    input  wire logic       square_wave,
    output logic            irq_or_refclk_pin_o,
    output logic            irq_or_refclk_pin_oe,
    output logic            irq_or_squarewave_pin
);
    logic [7:0] cfg1_ff, cfg2_ff, inten_ff, flags_ff, nxt_flags;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] alm_ff [0:5];
    rtcal_cal_t shadow_ff, run_ff, nxt_run, rd_cal;
    logic [1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_lvl_ff;
    logic       set_prev_ff, chk_ff, load, rd_flags, any_set, a1_hit;
    logic       inta_ff, intb_ff;
    logic       m_sec, m_min, m_hrs, m_dd, m_mon, m_yr;
    logic [7:0] month_end;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // leap years within the two-digit range; the 2100 exception is not modelled
    function automatic logic [7:0] days_in(input logic [4:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            5'h02:                      days_in = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: days_in = 8'h30;
            default:                    days_in = 8'h31;
        endcase
    endfunction

    // pins from another domain: a level counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_s1_ff  <= 2'h0;
            pin_s2_ff  <= 2'h0;
            pin_s3_ff  <= 2'h0;
            pin_lvl_ff <= 2'h0;
        end else begin
            pin_s1_ff  <= {ref_deviation_pin, osc_stopped_pin};
            pin_s2_ff  <= pin_s1_ff;
            pin_s3_ff  <= pin_s2_ff;
            pin_lvl_ff <= (~(pin_s2_ff ^ pin_s3_ff) & pin_s3_ff) | ((pin_s2_ff ^ pin_s3_ff) & pin_lvl_ff);
        end
    end

    // configuration and enable registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg1_ff  <= RTCAL_RST_CFG1;
            cfg2_ff  <= RTCAL_RST_CFG2;
            inten_ff <= RTCAL_RST_INTEN;
        end else if (reg_req.we) begin
            if (reg_req.addr == RTCAL_OFS_CFG1)
                cfg1_ff <= reg_req.wdata;
            if (reg_req.addr == RTCAL_OFS_CFG2)
                cfg2_ff <= reg_req.wdata & RTCAL_MSK_CFG2;
            if (reg_req.addr == RTCAL_OFS_INTEN)
                inten_ff <= reg_req.wdata & RTCAL_MSK_INTEN;
        end
    end

    // programmed calendar and alarm one settings
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shadow_ff <= RTCAL_RST_CAL;
            for (int i = 0; i < 6; i++)
                alm_ff[i] <= 8'h00;
            alm_ff[4] <= RTCAL_RST_ALMON;
        end else if (reg_req.we) begin
            case (reg_req.addr)
                RTCAL_OFS_SEC:  shadow_ff.sec  <= reg_req.wdata & RTCAL_MSK_SEC;
                RTCAL_OFS_MIN:  shadow_ff.min  <= reg_req.wdata & RTCAL_MSK_SEC;
                RTCAL_OFS_HRS:  shadow_ff.hrs  <= reg_req.wdata & RTCAL_MSK_HRS;
                RTCAL_OFS_WDAY: shadow_ff.wday <= reg_req.wdata & RTCAL_MSK_WDAY;
                RTCAL_OFS_MDAY: shadow_ff.mday <= reg_req.wdata & RTCAL_MSK_HRS;
                RTCAL_OFS_MON:  shadow_ff.mon  <= reg_req.wdata & RTCAL_MSK_MON;
                RTCAL_OFS_YEAR: shadow_ff.year <= reg_req.wdata;
                default: begin
                    if (reg_req.addr >= RTCAL_OFS_ALM && reg_req.addr <= RTCAL_OFS_ALM_L)
                        alm_ff[3'(reg_req.addr - RTCAL_OFS_ALM)] <=
                            (reg_req.addr == RTCAL_OFS_ALM + 8'h04) ? (reg_req.wdata & RTCAL_MSK_ALMON)
                                                                   : reg_req.wdata;
                end
            endcase
        end
    end

    assign load = cfg2_ff[RTCAL_B_SET] & ~set_prev_ff;

    always_comb begin
        month_end = days_in(run_ff.mon[4:0], run_ff.year);
        nxt_run   = run_ff;
        if (run_ff.sec != RTCAL_MAX_SEC) begin
            nxt_run.sec = bcd_inc(run_ff.sec);
        end else begin
            nxt_run.sec = 8'h00;
            if (run_ff.min != RTCAL_MAX_SEC) begin
                nxt_run.min = bcd_inc(run_ff.min);
            end else begin
                nxt_run.min = 8'h00;
                if (run_ff.hrs != RTCAL_MAX_HRS) begin
                    nxt_run.hrs = bcd_inc(run_ff.hrs);
                end else begin
                    nxt_run.hrs = 8'h00;
                    nxt_run.wday = (run_ff.wday == RTCAL_MAX_WDAY) ? RTCAL_ONE : run_ff.wday + RTCAL_ONE;
                    if (run_ff.mday != month_end) begin
                        nxt_run.mday = bcd_inc(run_ff.mday);
                    end else begin
                        nxt_run.mday = RTCAL_ONE;
                        if (run_ff.mon[4:0] != RTCAL_MAX_MON[4:0]) begin
                            nxt_run.mon = {run_ff.mon[7], 2'h0, 5'(bcd_inc({3'h0, run_ff.mon[4:0]}))};
                        end else begin
                            nxt_run.mon = {run_ff.mon[7], 7'h01};
                            if (run_ff.year != RTCAL_MAX_YEAR) begin
                                nxt_run.year = bcd_inc(run_ff.year);
                            end else begin
                                nxt_run.year = 8'h00;
                                nxt_run.mon[RTCAL_B_CENT] = ~run_ff.mon[RTCAL_B_CENT];
                            end
                        end
                    end
                end
            end
        end
    end

    // running chain; a set-time load beats a coincident tick
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_ff      <= RTCAL_RST_CAL;
            set_prev_ff <= 1'b0;
            chk_ff      <= 1'b0;
        end else begin
            set_prev_ff <= cfg2_ff[RTCAL_B_SET];
            // alarm compare waits a cycle so it sees the advanced time
            chk_ff      <= sec_tick & ~load;
            if (load)
                run_ff <= shadow_ff;
            else if (sec_tick)
                run_ff <= nxt_run;
        end
    end

    always_comb begin
        m_sec = alm_ff[0][7] | (alm_ff[0][6:0] == run_ff.sec[6:0]);
        m_min = alm_ff[1][7] | (alm_ff[1][6:0] == run_ff.min[6:0]);
        m_hrs = alm_ff[2][7] | (alm_ff[2][5:0] == run_ff.hrs[5:0]);
        // day select picks weekday or date
        m_dd  = alm_ff[3][7] | (alm_ff[3][RTCAL_B_DYDT] ? (alm_ff[3][2:0] == run_ff.wday[2:0])
                                                        : (alm_ff[3][5:0] == run_ff.mday[5:0]));
        m_mon = alm_ff[4][RTCAL_B_MMASK] | (alm_ff[4][4:0] == run_ff.mon[4:0]);
        m_yr  = alm_ff[4][RTCAL_B_YMASK] | (alm_ff[5] == run_ff.year);
        a1_hit = m_sec & m_min & m_hrs & m_dd & m_mon & m_yr;
    end

    assign rd_flags = reg_req.re && (reg_req.addr == RTCAL_OFS_FLAGS);

    // status flags: a set in the clearing cycle wins
    always_comb begin
        nxt_flags = rd_flags ? 8'h00 : flags_ff;
        // only with the external reference on
        if (pin_lvl_ff[1] && cfg1_ff[RTCAL_B_EXT_REFERENCE_ENABLE])
            nxt_flags[RTCAL_B_LOS] = 1'b1;
        // stop detect, suppressed by the disable bit
        if (pin_lvl_ff[0])
            nxt_flags[RTCAL_B_OSF] = 1'b1;
        if (inten_ff[RTCAL_B_OSC_FLAG_DISABLE])
            nxt_flags[RTCAL_B_OSF] = 1'b0;
        if (countdown_zero)
            nxt_flags[RTCAL_B_TIF] = 1'b1;
        if (alarm_two_match)
            nxt_flags[RTCAL_B_A2F] = 1'b1;
        if (chk_ff && a1_hit)
            nxt_flags[RTCAL_B_A1F] = 1'b1;
        // a set in the clearing cycle survives; the clear check skips those cycles
        any_set = (nxt_flags & ~(rd_flags ? 8'h00 : flags_ff)) != 8'h00;
    end

    always_ff @(posedge clk) begin
        if (!rst_b)
            flags_ff <= RTCAL_RST_FLAGS;
        else
            flags_ff <= nxt_flags;
    end

    // read data; the read-select bit chooses live or programmed time
    always_comb begin
        rd_cal    = cfg2_ff[RTCAL_B_RDRUN] ? run_ff : shadow_ff;
        nxt_rdata = 8'h00;
        case (reg_req.addr)
            RTCAL_OFS_CFG1:  nxt_rdata = cfg1_ff;
            RTCAL_OFS_CFG2:  nxt_rdata = cfg2_ff;
            RTCAL_OFS_INTEN: nxt_rdata = inten_ff;
            RTCAL_OFS_FLAGS: nxt_rdata = flags_ff & RTCAL_MSK_FLAGS;
            RTCAL_OFS_SEC:   nxt_rdata = rd_cal.sec;
            RTCAL_OFS_MIN:   nxt_rdata = rd_cal.min;
            RTCAL_OFS_HRS:   nxt_rdata = rd_cal.hrs;
            RTCAL_OFS_WDAY:  nxt_rdata = rd_cal.wday;
            RTCAL_OFS_MDAY:  nxt_rdata = rd_cal.mday;
            RTCAL_OFS_MON:   nxt_rdata = rd_cal.mon;
            RTCAL_OFS_YEAR:  nxt_rdata = rd_cal.year;
            default: begin
                if (reg_req.addr >= RTCAL_OFS_ALM && reg_req.addr <= RTCAL_OFS_ALM_L)
                    nxt_rdata = alm_ff[3'(reg_req.addr - RTCAL_OFS_ALM)];
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b)
            rdata_ff <= 8'h00;
        else if (reg_req.re)
            rdata_ff <= nxt_rdata;
    end

    // interrupt pins, both active low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            inta_ff <= 1'b0;
            intb_ff <= 1'b1;
        end else begin
            // enable bit gates the alarm interrupt
            // alarm one pulls the pin, not while it serves as reference input
            inta_ff <= flags_ff[RTCAL_B_A1F] & inten_ff[RTCAL_B_ALARM_ONE_IRQ_ENABLE] & ~cfg1_ff[RTCAL_B_EXT_REFERENCE_ENABLE];
            if (cfg1_ff[RTCAL_B_PIN_FUNCTION_SELECT])
                intb_ff <= ~((flags_ff[RTCAL_B_A1F] & inten_ff[RTCAL_B_ALARM_ONE_IRQ_ENABLE]) |
                             (flags_ff[RTCAL_B_A2F] & inten_ff[RTCAL_B_A2IE]) |
                             (flags_ff[RTCAL_B_TIF] & inten_ff[RTCAL_B_TIE]));
            else
                intb_ff <= square_wave;
        end
    end

    assign reg_rdata             = rdata_ff;
    assign irq_or_refclk_pin_o   = 1'b0;
    assign irq_or_refclk_pin_oe  = inta_ff;
    assign irq_or_squarewave_pin = intb_ff;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_set_rise;
        !cfg2_ff[RTCAL_B_SET] ##1 cfg2_ff[RTCAL_B_SET];
    endsequence
    sequence s_day_end;
        sec_tick && !load && run_ff.sec == RTCAL_MAX_SEC && run_ff.min == RTCAL_MAX_SEC
            && run_ff.hrs == RTCAL_MAX_HRS;
    endsequence

    a_alarm_irq_gate: assert property (irq_or_refclk_pin_oe |-> $past(inten_ff[RTCAL_B_ALARM_ONE_IRQ_ENABLE])
        && $past(flags_ff[RTCAL_B_A1F], 1)) else $error("irq pin driven without enable");
    a_flags_read_clear: assert property (rd_flags && !any_set |=> flags_ff == 8'h00)
        else $error("flag read did not clear");
    a_los_needs_ref: assert property (!cfg1_ff[RTCAL_B_EXT_REFERENCE_ENABLE] && !flags_ff[RTCAL_B_LOS] |=>
        !flags_ff[RTCAL_B_LOS]) else $error("reference flag set without external mode");
    a_osf_disabled: assert property (inten_ff[RTCAL_B_OSC_FLAG_DISABLE] |=> !flags_ff[RTCAL_B_OSF])
        else $error("oscillator flag shown while disabled");
    a_tif_event: assert property (countdown_zero |=> flags_ff[RTCAL_B_TIF])
        else $error("countdown flag missed");
    a_a2f_event: assert property (alarm_two_match |=> flags_ff[RTCAL_B_A2F])
        else $error("second alarm flag missed");
    a_a1f_match: assert property (sec_tick && !load ##1 a1_hit |=> flags_ff[RTCAL_B_A1F])
        else $error("first alarm flag missed");
    a_set_time_load: assert property (s_set_rise |=> run_ff == $past(shadow_ff))
        else $error("set-time edge did not load chain");
    a_sec_rollover: assert property (sec_tick && !load && run_ff.sec == RTCAL_MAX_SEC |=>
        run_ff.sec == 8'h00 && run_ff.min != $past(run_ff.min)) else $error("seconds carry wrong");
    a_weekday_wrap: assert property (s_day_end ##0 run_ff.wday == RTCAL_MAX_WDAY |=>
        run_ff.wday == RTCAL_ONE) else $error("weekday did not wrap to one");
    a_pin_select: assert property (!cfg1_ff[RTCAL_B_PIN_FUNCTION_SELECT] |=>
        irq_or_squarewave_pin == $past(square_wave)) else $error("square wave not routed");
    a_min_rollover: assert property (sec_tick && !load && run_ff.sec == RTCAL_MAX_SEC &&
        run_ff.min == RTCAL_MAX_SEC |=> run_ff.min == 8'h00) else $error("minutes carry wrong");
    a_chain_holds: assert property (!sec_tick && !load |=> run_ff == $past(run_ff))
        else $error("calendar moved without a tick");
    a_los_sets: assert property (pin_lvl_ff[1] && cfg1_ff[RTCAL_B_EXT_REFERENCE_ENABLE] |=> flags_ff[RTCAL_B_LOS])
        else $error("reference flag missed");
    a_osf_sets: assert property (pin_lvl_ff[0] && !inten_ff[RTCAL_B_OSC_FLAG_DISABLE] |=> flags_ff[RTCAL_B_OSF])
        else $error("oscillator flag missed");
    a_irq_pin_drive: assert property (flags_ff[RTCAL_B_A1F] && inten_ff[RTCAL_B_ALARM_ONE_IRQ_ENABLE] &&
        !cfg1_ff[RTCAL_B_EXT_REFERENCE_ENABLE] |=> irq_or_refclk_pin_oe) else $error("alarm interrupt not driven");
    a_shared_pin_irq: assert property (cfg1_ff[RTCAL_B_PIN_FUNCTION_SELECT] && flags_ff[RTCAL_B_A1F] &&
        inten_ff[RTCAL_B_ALARM_ONE_IRQ_ENABLE] |=> !irq_or_squarewave_pin) else $error("shared pin missed interrupt");
endmodule
`default_nettype wire

// [verification/rtcal_host.sv]
// host model issuing register writes and reads to the rtc core
`default_nettype none
module rtcal_host
    import rtcal_pkg::*;
(
    input  wire logic       clk,
    output var rtcal_req_t  reg_req,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial reg_req = '0;

    // idle cycles scramble address and data so nothing leans on stale values
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        reg_req <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
    endtask

    task automatic rd(input logic [7:0] a, input int gap, output logic [7:0] d);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h5a, we: 1'b0, re: 1'b1};
        @(posedge clk);
        reg_req <= '{addr: ~a, wdata: 8'ha5, we: 1'b0, re: 1'b0};
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [verification/rtc_calendar_status_alarm_one_test.sv]
// self-checking bench for the rtc calendar, flags and first alarm
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %0t value %h expected %h", $time, got, exp); end end
module rtc_calendar_status_alarm_one_test
    import rtcal_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk, rst_b, sec_tick, osc_stop, ref_dev, cd_zero, a2_match, sq_wave;
    rtcal_req_t reg_req;
    logic [7:0] reg_rdata, rd_val;
    logic       pin_o, pin_oe, sqw_pin;
    int         error_cnt = 0;
    int         n_tests = 0;
    logic [7:0] cal_rst [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    logic [7:0] cal_end [7] = '{8'h59, 8'h59, 8'h63, 8'h07, 8'h31, 8'h12, 8'h99};
    logic [7:0] cal_new [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00};
    logic [7:0] cal_base [7] = '{8'h29, 8'h20, 8'h10, 8'h03, 8'h15, 8'h06, 8'h24};
    // alarm regs 0x0d..0x12 per case; only listed mask combinations are used
    logic [7:0] alm [16][6] = '{
        '{8'h80, 8'h80, 8'h80, 8'h80, 8'hc0, 8'h00}, '{8'h30, 8'h80, 8'h80, 8'h80, 8'hc0, 8'h00},
        '{8'h31, 8'h80, 8'h80, 8'h80, 8'hc0, 8'h00}, '{8'h30, 8'h20, 8'h80, 8'h80, 8'hc0, 8'h00},
        '{8'h30, 8'h21, 8'h80, 8'h80, 8'hc0, 8'h00}, '{8'h30, 8'h20, 8'h10, 8'h80, 8'hc0, 8'h00},
        '{8'h30, 8'h20, 8'h11, 8'h80, 8'hc0, 8'h00}, '{8'h30, 8'h20, 8'h10, 8'h15, 8'hc0, 8'h00},
        '{8'h30, 8'h20, 8'h10, 8'h16, 8'hc0, 8'h00}, '{8'h30, 8'h20, 8'h10, 8'h15, 8'h46, 8'h00},
        '{8'h30, 8'h20, 8'h10, 8'h15, 8'h47, 8'h00}, '{8'h30, 8'h20, 8'h10, 8'h15, 8'h06, 8'h24},
        '{8'h30, 8'h20, 8'h10, 8'h15, 8'h06, 8'h25}, '{8'h30, 8'h20, 8'h10, 8'h43, 8'hc0, 8'h00},
        '{8'h30, 8'h20, 8'h10, 8'h44, 8'hc0, 8'h00}, '{8'h30, 8'h20, 8'h10, 8'h03, 8'hc0, 8'h00}};
    logic [15:0] hits = 16'h2aab;

    rtcal_core rtcal_core_inst (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .sec_tick(sec_tick), .osc_stopped_pin(osc_stop), .ref_deviation_pin(ref_dev),
        .countdown_zero(cd_zero), .alarm_two_match(a2_match), .square_wave(sq_wave),
        .irq_or_refclk_pin_o(pin_o), .irq_or_refclk_pin_oe(pin_oe), .irq_or_squarewave_pin(sqw_pin));
    rtcal_host rtcal_host_inst (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        rtcal_host_inst.rd(a, 0, rd_val);
        `CHK(rd_val, exp)
    endtask

    task automatic tick();
        @(posedge clk);
        sec_tick <= 1'b1;
        @(posedge clk);
        sec_tick <= 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bench runs under a thousand cycles; this cuts a hang well past that
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        {rst_b, sec_tick, osc_stop, ref_dev, cd_zero, a2_match, sq_wave} <= '0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(RTCAL_OFS_FLAGS, 8'h40);
        rd_chk(RTCAL_OFS_FLAGS, 8'h00);
        for (int i = 0; i < 7; i++) rd_chk(RTCAL_OFS_SEC + 8'(i), cal_rst[i]);
        rtcal_host_inst.wr(8'h20, 8'h5a, 0);
        rd_chk(8'h20, 8'h00);
        @(posedge clk);
        {cd_zero, a2_match} <= 2'b11;
        @(posedge clk);
        {cd_zero, a2_match} <= 2'b00;
        rd_chk(RTCAL_OFS_FLAGS, 8'h06);
        rd_chk(RTCAL_OFS_FLAGS, 8'h00);
        @(posedge clk) osc_stop <= 1'b1;
        wait_n(6);
        rd_chk(RTCAL_OFS_FLAGS, 8'h40);
        rtcal_host_inst.wr(RTCAL_OFS_INTEN, 8'h40, 0);
        rtcal_host_inst.rd(RTCAL_OFS_FLAGS, 0, rd_val);
        wait_n(6);
        rd_chk(RTCAL_OFS_FLAGS, 8'h00);
        @(posedge clk) osc_stop <= 1'b0;
        ref_dev <= 1'b1;
        wait_n(6);
        rd_chk(RTCAL_OFS_FLAGS, 8'h00);
        rtcal_host_inst.wr(RTCAL_OFS_CFG1, 8'h8e, 0);
        wait_n(6);
        rd_chk(RTCAL_OFS_FLAGS, 8'h80);
        @(posedge clk) ref_dev <= 1'b0;
        rtcal_host_inst.wr(RTCAL_OFS_CFG1, 8'h0e, 0);
        sq_wave <= 1'b1;
        wait_n(3);
        `CHK(sqw_pin, 1'b1)
        @(posedge clk) sq_wave <= 1'b0;
        wait_n(3);
        `CHK(sqw_pin, 1'b0)
        for (int i = 0; i < 7; i++) rtcal_host_inst.wr(RTCAL_OFS_SEC + 8'(i), cal_end[i], i % 2);
        rtcal_host_inst.wr(RTCAL_OFS_CFG2, 8'h0e, 0);
        tick();
        for (int i = 0; i < 7; i++) rd_chk(RTCAL_OFS_SEC + 8'(i), cal_new[i]);
        rtcal_host_inst.wr(RTCAL_OFS_CFG2, 8'h0a, 0);
        rd_chk(RTCAL_OFS_HRS, 8'h23);
        for (int i = 0; i < 7; i++) rtcal_host_inst.wr(RTCAL_OFS_SEC + 8'(i), cal_base[i], 0);
        rtcal_host_inst.wr(RTCAL_OFS_CFG1, 8'h4e, 0);
        rtcal_host_inst.wr(RTCAL_OFS_INTEN, 8'h01, 0);
        sq_wave <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            for (int j = 0; j < 6; j++) rtcal_host_inst.wr(RTCAL_OFS_ALM + 8'(j), alm[c][j], c % 3);
            rtcal_host_inst.wr(RTCAL_OFS_CFG2, 8'h0c, 0);
            rtcal_host_inst.wr(RTCAL_OFS_CFG2, 8'h0e, 0);
            rtcal_host_inst.rd(RTCAL_OFS_FLAGS, 0, rd_val);
            tick();
            wait_n(4);
            `CHK(pin_oe, hits[c])
            `CHK(sqw_pin, ~hits[c])
            `CHK(pin_o, 1'b0)
            rd_chk(RTCAL_OFS_FLAGS, {7'h00, hits[c]});
        end
        rd_chk(RTCAL_OFS_ALM + 8'h04, 8'hc0);
        rtcal_host_inst.wr(RTCAL_OFS_ALM + 8'h04, 8'hff, 0);
        rd_chk(RTCAL_OFS_ALM + 8'h04, 8'hdf);
        for (int j = 0; j < 4; j++) rtcal_host_inst.wr(RTCAL_OFS_ALM + 8'(j), 8'h80, 0);
        rtcal_host_inst.wr(RTCAL_OFS_INTEN, 8'h00, 0);
        rtcal_host_inst.rd(RTCAL_OFS_FLAGS, 0, rd_val);
        tick();
        wait_n(4);
        `CHK(pin_oe, 1'b0)
        rd_chk(RTCAL_OFS_FLAGS, 8'h01);
        complete_run();
    end
endmodule
`default_nettype wire
